// file: src/iodc_pkg.sv
/*
 * Shared constants and types of the I/O device controller transfer block.
 * Assumes a single synchronous clock domain with all inputs on that clock.
 */
package iodc_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 16;
    localparam int CNT_W = 12;
    localparam int CHAR_W = 8;
    // Control word bits of the direct control command.
    localparam int CTL_RDIE_BIT = 0;
    localparam int CTL_WRIE_BIT = 1;
    // Status word bits returned by the direct test command.
    localparam int STS_WRIE = 0;
    localparam int STS_RDIE = 1;
    localparam int STS_TXBUSY = 2;
    localparam int STS_RXFULL = 3;
    localparam int STS_IRQ = 4;

    typedef enum logic [1:0] {
        CH_READ = 2'h0,
        CH_WRITE = 2'h1,
        CH_IRQ = 2'h2,
        CH_END = 2'h3
    } iodc_chop_t;

    typedef enum logic [1:0] {
        DIR_READ = 2'h0,
        DIR_WRITE = 2'h1,
        DIR_TEST = 2'h2,
        DIR_CONTROL = 2'h3
    } iodc_dirop_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_FETCH = 6'h02,
        ST_RXWAIT = 6'h04,
        ST_MEMWR = 6'h08,
        ST_MEMRD = 6'h10,
        ST_TXWAIT = 6'h20
    } iodc_state_t;

    typedef struct packed {
        iodc_chop_t op;
        logic [CNT_W-1:0] count;
        logic [ADDR_W-1:0] addr;
    } iodc_chcmd_t;

    typedef struct packed {
        logic valid;
        iodc_dirop_t op;
        logic [WORD_W-1:0] data;
    } iodc_dircmd_t;

    typedef struct packed {
        iodc_state_t fsm;
        logic [ADDR_W-1:0] progPtr;
        logic chanReq;
        logic [ADDR_W-1:0] bufAddr;
        logic [CNT_W-1:0] count;
        logic memReq;
        logic memWrite;
        logic [WORD_W-1:0] memWData;
        logic [CHAR_W-1:0] rxChar;
        logic rxFull;
        logic rdIe;
        logic wrIe;
        logic readEn;
        logic txValid;
        logic [CHAR_W-1:0] txData;
        logic txBusy;
        logic irq;
        logic dirAck;
        logic [WORD_W-1:0] dirRData;
    } iodc_regs_t;

    localparam iodc_regs_t REGS_RST = '{fsm: ST_IDLE, default: '0};
endpackage

// file: src/iodc_controller.sv
/*
 * Device controller: channel-driven block transfer and direct character
 * transfer with a single external interrupt request.
 * Assumes the channel, memory, processor and peripheral all run on core_clk.
 */
// Function
// - Start command loads program pointer entry.
// - Read/write command moves block of given length.
// - Program requests interrupt after block, then ends.
// - Interrupt command raises external interrupt.
// - Control command sets read interrupt enable.
// - Write enable interrupts for first character.
// - Read enable starts peripheral read, captures character.
// - Captured character interrupts the processor.
// - Direct read returns character, starts next read.
// - Direct write hands one character over.
// - Written character goes on to peripheral.
// - Finished write raises interrupt for next.
// - Direct transfers never use the channel.
// - Each direct command moves exactly one word.
`timescale 1ns/100ps
module iodc_controller import iodc_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Start program command
    input wire logic startProgCmd,
    input wire logic [ADDR_W-1:0] startProgAddr,
    output logic [ADDR_W-1:0] drtPtr,
    // Channel command port
    input wire logic chanCmdValid,
    input wire iodc_chcmd_t chanCmd,
    output logic chanCmdDemand,
    // Memory buffer port
    output logic memReq,
    output logic memWrite,
    output logic [ADDR_W-1:0] memAddr,
    output logic [WORD_W-1:0] memWData,
    input wire logic memAck,
    input wire logic [WORD_W-1:0] memRData,
    // Direct command port
    input wire iodc_dircmd_t dirCmd,
    output logic dirAck,
    output logic [WORD_W-1:0] dirRData,
    // Peripheral port
    output logic periphReadEn,
    input wire logic periphRxValid,
    input wire logic [CHAR_W-1:0] periphRxData,
    output logic periphTxValid,
    output logic [CHAR_W-1:0] periphTxData,
    input wire logic periphTxDone,
    // Interrupt
    output logic extIrq
);
    iodc_regs_t q;
    iodc_regs_t d;
    logic dirWr;
    logic [WORD_W-1:0] sts;

    assign dirWr = dirCmd.valid && (dirCmd.op == DIR_WRITE);

    always_comb begin
        sts = '0;
        sts[STS_WRIE] = q.wrIe;
        sts[STS_RDIE] = q.rdIe;
        sts[STS_TXBUSY] = q.txBusy;
        sts[STS_RXFULL] = q.rxFull;
        sts[STS_IRQ] = q.irq;
        d = q;
        d.dirAck = 1'b0;
        d.readEn = 1'b0;
        d.txValid = 1'b0;
        // Direct commands go straight to the controller, not the channel.
        if (dirCmd.valid) begin
            d.dirAck = 1'b1;
            unique case (dirCmd.op)
                DIR_READ: begin
                    d.dirRData = WORD_W'(q.rxChar);
                    d.rxFull = 1'b0;
                    d.irq = 1'b0;
                    d.readEn = 1'b1;
                end
                DIR_WRITE: begin
                    d.txData = dirCmd.data[CHAR_W-1:0];
                    d.txValid = 1'b1;
                    d.txBusy = 1'b1;
                    d.irq = 1'b0;
                end
                DIR_TEST: begin
                    d.dirRData = sts;
                end
                DIR_CONTROL: begin
                    d.rdIe = dirCmd.data[CTL_RDIE_BIT];
                    d.wrIe = dirCmd.data[CTL_WRIE_BIT];
                    d.irq = 1'b0;
                    if (dirCmd.data[CTL_RDIE_BIT]) begin
                        d.readEn = 1'b1;
                    end
                    if (dirCmd.data[CTL_WRIE_BIT] && !q.txBusy) begin
                        d.irq = 1'b1;
                    end
                end
            endcase
        end
        // Peripheral events come after the clears so that a set wins.
        if (periphRxValid && q.fsm != ST_RXWAIT) begin
            d.rxChar = periphRxData;
            d.rxFull = 1'b1;
            if (q.rdIe) begin
                d.irq = 1'b1;
            end
        end
        if (periphTxDone && q.txBusy) begin
            if (!dirWr) begin
                d.txBusy = 1'b0;
            end
            if (q.wrIe) begin
                d.irq = 1'b1;
            end
        end
        unique case (q.fsm)
            ST_IDLE: begin
                if (startProgCmd) begin
                    d.progPtr = startProgAddr;
                    d.fsm = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (chanCmdValid) begin
                    d.bufAddr = chanCmd.addr;
                    d.count = chanCmd.count;
                    unique case (chanCmd.op)
                        CH_READ: begin
                            if (chanCmd.count != '0) begin
                                d.fsm = ST_RXWAIT;
                                d.readEn = 1'b1;
                            end
                        end
                        CH_WRITE: begin
                            if (chanCmd.count != '0) begin
                                d.fsm = ST_MEMRD;
                                d.memReq = 1'b1;
                                d.memWrite = 1'b0;
                            end
                        end
                        CH_IRQ: begin
                            d.irq = 1'b1;
                        end
                        CH_END: begin
                            d.fsm = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_RXWAIT: begin
                if (periphRxValid) begin
                    d.memWData = WORD_W'(periphRxData);
                    d.memReq = 1'b1;
                    d.memWrite = 1'b1;
                    d.fsm = ST_MEMWR;
                end
            end
            ST_MEMWR: begin
                if (memAck) begin
                    d.memReq = 1'b0;
                    d.bufAddr = q.bufAddr + ADDR_W'(1);
                    d.count = q.count - CNT_W'(1);
                    if (q.count == CNT_W'(1)) begin
                        d.fsm = ST_FETCH;
                    end else begin
                        d.fsm = ST_RXWAIT;
                        d.readEn = 1'b1;
                    end
                end
            end
            ST_MEMRD: begin
                if (memAck) begin
                    d.memReq = 1'b0;
                    d.txData = memRData[CHAR_W-1:0];
                    d.txValid = 1'b1;
                    d.fsm = ST_TXWAIT;
                end
            end
            ST_TXWAIT: begin
                if (periphTxDone) begin
                    d.bufAddr = q.bufAddr + ADDR_W'(1);
                    d.count = q.count - CNT_W'(1);
                    if (q.count == CNT_W'(1)) begin
                        d.fsm = ST_FETCH;
                    end else begin
                        d.fsm = ST_MEMRD;
                        d.memReq = 1'b1;
                    end
                end
            end
        endcase
        d.chanReq = (d.fsm == ST_FETCH);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= REGS_RST;
        end else begin
            q <= d;
        end
    end

    assign drtPtr = q.progPtr;
    assign chanCmdDemand = q.chanReq;
    assign memReq = q.memReq;
    assign memWrite = q.memWrite;
    assign memAddr = q.bufAddr;
    assign memWData = q.memWData;
    assign dirAck = q.dirAck;
    assign dirRData = q.dirRData;
    assign periphReadEn = q.readEn;
    assign periphTxValid = q.txValid;
    assign periphTxData = q.txData;
    assign extIrq = q.irq;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence chanTake(iodc_chop_t op);
        q.fsm == ST_FETCH && chanCmdValid && chanCmd.op == op;
    endsequence
    sequence dirTake(iodc_dirop_t op);
        dirCmd.valid && dirCmd.op == op;
    endsequence

    start_ptr_a: assert property (q.fsm == ST_IDLE && startProgCmd |=>
        drtPtr == $past(startProgAddr) && chanCmdDemand)
        else $error("Start command did not load the pointer.");
    demand_fetch_a: assert property (chanCmdDemand && !chanCmdValid |=>
        chanCmdDemand && q.fsm == ST_FETCH)
        else $error("Command demand dropped without a command.");
    block_len_a: assert property (chanTake(CH_READ) and
        (chanCmd.count != '0) |=> q.fsm == ST_RXWAIT &&
        q.count == $past(chanCmd.count) && periphReadEn)
        else $error("Block length not taken from the command.");
    irq_cmd_a: assert property (chanTake(CH_IRQ) |=> extIrq)
        else $error("Interrupt command did not raise the interrupt.");
    prog_end_a: assert property (chanTake(CH_END) |=>
        !chanCmdDemand && q.fsm == ST_IDLE)
        else $error("Program end did not stop the demand.");
    rdie_set_a: assert property (dirTake(DIR_CONTROL) and
        dirCmd.data[CTL_RDIE_BIT] |=> q.rdIe && periphReadEn)
        else $error("Read enable did not start a read.");
    wrie_irq_a: assert property (dirTake(DIR_CONTROL) and
        (dirCmd.data[CTL_WRIE_BIT] && !q.txBusy) |=> extIrq)
        else $error("Write enable gave no first interrupt.");
    rx_irq_a: assert property (periphRxValid && q.fsm != ST_RXWAIT &&
        q.rdIe |=> extIrq && q.rxChar == $past(periphRxData))
        else $error("Received character gave no interrupt.");
    dir_read_a: assert property (dirTake(DIR_READ) |=> dirAck &&
        dirRData[CHAR_W-1:0] == $past(q.rxChar) && periphReadEn)
        else $error("Direct read returned the wrong character.");
    dir_write_a: assert property (dirTake(DIR_WRITE) |=>
        periphTxValid && periphTxData == $past(dirCmd.data[CHAR_W-1:0]))
        else $error("Written character not sent on.");
    tx_irq_a: assert property (periphTxDone && q.txBusy && q.wrIe |=>
        extIrq)
        else $error("Finished write gave no interrupt.");
    irq_hold_a: assert property (extIrq && !(dirCmd.valid &&
        dirCmd.op != DIR_TEST) |=> extIrq)
        else $error("Interrupt dropped without service.");
    no_chan_a: assert property (dirCmd.valid && q.fsm == ST_IDLE &&
        !startProgCmd |=> !chanCmdDemand && q.fsm == ST_IDLE)
        else $error("Direct command touched the channel.");
    one_word_a: assert property (dirCmd.valid |=> dirAck)
        else $error("Direct command not answered in one cycle.");
endmodule // iodc_controller

// file: tb/iodc_periph_model.sv
/*
 * Peripheral and memory buffer model for the device controller bench.
 * Assumes it shares core_clk and arst_n with the controller.
 */
`timescale 1ns/100ps
module iodc_periph_model import iodc_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Peripheral side
    input wire logic periphReadEn,
    output logic periphRxValid,
    output logic [CHAR_W-1:0] periphRxData,
    input wire logic periphTxValid,
    input wire logic [CHAR_W-1:0] periphTxData,
    output logic periphTxDone,
    // Memory side
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic [ADDR_W-1:0] memAddr,
    input wire logic [WORD_W-1:0] memWData,
    output logic memAck,
    output logic [WORD_W-1:0] memRData
);
    logic [WORD_W-1:0] memArr [256];
    logic [CHAR_W-1:0] txLog [8];
    int rxCnt, txCnt, rxWait, txWait, memWait;
    initial begin
        for (int i = 0; i < 256; i++) begin
            memArr[i] = 16'h1200 + i[15:0];
        end
    end
    // Stale lines show the inverse of the last value once released.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            {periphRxValid, periphTxDone, memAck} <= 3'h0;
            {periphRxData, memRData} <= '0;
            {rxCnt, txCnt, rxWait, txWait, memWait} <= '0;
        end else begin
            {periphRxValid, periphTxDone, memAck} <= 3'h0;
            if (periphRxValid) periphRxData <= ~periphRxData;
            if (memAck) memRData <= ~memRData;
            if (rxWait > 0) rxWait <= rxWait - 1;
            else if (periphReadEn) rxWait <= 3;
            if (rxWait == 1) begin
                periphRxValid <= 1'b1;
                periphRxData <= 8'hA0 + rxCnt[7:0];
                rxCnt <= rxCnt + 1;
            end
            if (periphTxValid) begin
                txLog[txCnt[2:0]] <= periphTxData;
                txCnt <= txCnt + 1;
                txWait <= 4;
            end else if (txWait > 0) txWait <= txWait - 1;
            if (txWait == 1 && !periphTxValid) periphTxDone <= 1'b1;
            if (memWait > 0) memWait <= memWait - 1;
            else if (memReq && !memAck) memWait <= 2;
            if (memWait == 1) begin
                memAck <= 1'b1;
                if (memWrite) memArr[memAddr[7:0]] <= memWData;
                memRData <= memArr[memAddr[7:0]];
            end
        end
    end
endmodule // iodc_periph_model

// file: tb/testbench.sv
/*
 * Self-checking bench of the device controller.
 * Assumes the controller and the peripheral model on one 20 MHz clock.
 */
`timescale 1ns/100ps
module testbench;
    import iodc_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic startProgCmd = 1'b0;
    logic [ADDR_W-1:0] startProgAddr = '0;
    logic chanCmdValid = 1'b0;
    iodc_chcmd_t chanCmd = '0;
    iodc_dircmd_t dirCmd = '0;
    logic [ADDR_W-1:0] drtPtr, memAddr;
    logic [WORD_W-1:0] memWData, memRData, dirRData;
    logic chanCmdDemand, memReq, memWrite, memAck, dirAck, extIrq;
    logic periphReadEn, periphRxValid, periphTxValid, periphTxDone;
    logic [CHAR_W-1:0] periphRxData, periphTxData;
    int fails = 0;
    int checks = 0;
    int cycles = 0;
    always #25 core_clk = ~core_clk;
    iodc_controller u_iodc_controller (.core_clk, .arst_n, .startProgCmd,
        .startProgAddr, .drtPtr, .chanCmdValid, .chanCmd, .chanCmdDemand,
        .memReq, .memWrite, .memAddr, .memWData, .memAck, .memRData,
        .dirCmd, .dirAck, .dirRData, .periphReadEn, .periphRxValid,
        .periphRxData, .periphTxValid, .periphTxData, .periphTxDone,
        .extIrq);
    iodc_periph_model u_iodc_periph_model (.core_clk, .arst_n,
        .periphReadEn, .periphRxValid, .periphRxData, .periphTxValid,
        .periphTxData, .periphTxDone, .memReq, .memWrite, .memAddr,
        .memWData, .memAck, .memRData);
    task automatic print_verdict();
        if (fails == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic waitIrq(input int n);
        for (int i = 0; i < n && extIrq !== 1'b1; i++) tick(1);
    endtask
    task automatic waitDemand();
        for (int i = 0; i < 400 && chanCmdDemand !== 1'b1; i++) tick(1);
    endtask
    task automatic start(input logic [15:0] a);
        @(posedge core_clk);
        startProgCmd <= 1'b1;
        startProgAddr <= a;
        @(posedge core_clk);
        startProgCmd <= 1'b0;
        #1;
    endtask
    task automatic ch(input iodc_chop_t op, input logic [11:0] n,
            input logic [15:0] a);
        waitDemand();
        @(posedge core_clk);
        chanCmdValid <= 1'b1;
        chanCmd <= '{op, n, a};
        @(posedge core_clk);
        chanCmdValid <= 1'b0;
        #1;
    endtask
    task automatic dir(input iodc_dirop_t op, input logic [15:0] d);
        @(posedge core_clk);
        dirCmd <= '{1'b1, op, d};
        @(posedge core_clk);
        dirCmd.valid <= 1'b0;
        #1;
        chk(dirAck, 1);
    endtask
    task automatic t_start();
        start(16'h0200);
        chk(drtPtr, 16'h0200);
        chk(chanCmdDemand, 1);
        start(16'h0300);
        chk(drtPtr, 16'h0200);
    endtask
    task automatic t_block();
        ch(CH_READ, 12'h002, 16'h0010);
        chk(chanCmdDemand, 0);
        waitDemand();
        chk(u_iodc_periph_model.memArr[16], 16'h00A0);
        chk(u_iodc_periph_model.memArr[17], 16'h00A1);
        ch(CH_WRITE, 12'h002, 16'h0040);
        waitDemand();
        chk(u_iodc_periph_model.txLog[0], 8'h40);
        chk(u_iodc_periph_model.txLog[1], 8'h41);
        ch(CH_READ, 12'h000, 16'h0010);
        chk({chanCmdDemand, periphReadEn}, 2'b10);
        ch(CH_IRQ, 12'h000, 16'h0000);
        chk(extIrq, 1);
        ch(CH_END, 12'h000, 16'h0000);
        chk(chanCmdDemand, 0);
        dir(DIR_CONTROL, 16'h0000);
        chk(extIrq, 0);
    endtask
    task automatic t_read();
        dir(DIR_CONTROL, 16'h0001);
        waitIrq(20);
        chk(extIrq, 1);
        chk({chanCmdDemand, memReq}, 0);
        dir(DIR_TEST, 16'h0000);
        chk(dirRData[4:0], 5'h1A);
        dir(DIR_READ, 16'h0000);
        chk(dirRData, 16'h00A2);
        chk(periphReadEn, 1);
        chk(extIrq, 0);
        waitIrq(20);
        chk(extIrq, 1);
        dir(DIR_CONTROL, 16'h0000);
        chk(extIrq, 0);
    endtask
    task automatic t_write();
        dir(DIR_CONTROL, 16'h0002);
        waitIrq(3);
        chk(extIrq, 1);
        dir(DIR_WRITE, 16'h0055);
        chk(periphTxValid, 1);
        chk(periphTxData, 8'h55);
        chk(extIrq, 0);
        chk({chanCmdDemand, memReq}, 0);
        waitIrq(20);
        chk(extIrq, 1);
        chk(u_iodc_periph_model.txLog[2], 8'h55);
        dir(DIR_CONTROL, 16'h0000);
    endtask
    task automatic t_reset();
        dir(DIR_CONTROL, 16'h0002);
        chk(extIrq, 1);
        @(posedge core_clk);
        arst_n <= 1'b0;
        #1;
        chk({extIrq, dirAck, chanCmdDemand}, 0);
        @(posedge core_clk);
        arst_n <= 1'b1;
        tick(1);
        start(16'h0100);
        chk(drtPtr, 16'h0100);
        chk(chanCmdDemand, 1);
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        tick(1);
        t_start();
        t_block();
        t_read();
        t_write();
        t_reset();
        print_verdict();
    end
endmodule // testbench
